/* File: src/vdc_pkg.sv */
// Constants and types for the video decoder two-wire control port
package vdc_pkg;
	// Bus addresses (8-bit form, R/W in bit 0)
	localparam logic [7:0]  DEV_WADDR     = 8'h86;
	localparam logic [7:0]  DEV_RADDR     = 8'h87;
	// Direct register subaddresses
	localparam logic [7:0]  SUB_MAKER_ID  = 8'h00;
	localparam logic [7:0]  SUB_STATUS    = 8'h35;
	localparam logic [7:0]  SUB_RD_ADDR   = 8'h36;
	localparam logic [7:0]  SUB_WR_ADDR   = 8'h37;
	localparam logic [7:0]  SUB_DATA      = 8'h38;
	localparam logic [7:0]  SUB_OUT_EN    = 8'hf2;
	// Field positions and reset values
	localparam int          STATUS_BUSY_BIT = 2;
	localparam logic [7:0]  OUT_EN_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	// Bit counts of one serial byte
	localparam logic [3:0]  BITS_IN_BYTE  = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT   = 4'h7;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_ADACK = 7'h04,
		ST_WRITE = 7'h08,
		ST_WRACK = 7'h10,
		ST_READ  = 7'h20,
		ST_RDACK = 7'h40
	} vdc_state_type;
endpackage : vdc_pkg

/* File: src/vdc_indirect.sv */
// Indirect access engine towards the coprocessor_ram register space
`timescale 1ns/10ps
module vdc_indirect
	import vdc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Commands from the serial side
	input  wire logic        rd_go_i,
	input  wire logic        wa_go_i,
	input  wire logic        dw_go_i,
	input  wire logic [15:0] word_i,
	// State towards the serial side
	output logic             busy_o,
	output logic [15:0]      hold_o,
	// coprocessor_ram port
	output logic             cop_req_o,
	output logic             cop_we_o,
	output logic [15:0]      cop_addr_o,
	output logic [15:0]      cop_wdata_o,
	input  wire logic        cop_ack_i,
	input  wire logic [15:0] cop_rdata_i
);
	logic [15:0] wr_addr_q;

	assign busy_o = cop_req_o;

	// Latched write target
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_addr_q <= WORD_RESET;
		end else if (wa_go_i && !cop_req_o) begin
			wr_addr_q <= word_i;
		end
	end

	// One pending transfer; busy until acknowledged
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cop_req_o   <= 1'b0;
			cop_we_o    <= 1'b0;
			cop_addr_o  <= WORD_RESET;
			cop_wdata_o <= WORD_RESET;
		end else if (cop_req_o) begin
			if (cop_ack_i) begin
				cop_req_o <= 1'b0;
			end
		end else if (rd_go_i) begin
			cop_req_o  <= 1'b1;
			cop_we_o   <= 1'b0;
			cop_addr_o <= word_i;
		end else if (dw_go_i) begin
			cop_req_o   <= 1'b1;
			cop_we_o    <= 1'b1;
			cop_addr_o  <= wr_addr_q;
			cop_wdata_o <= word_i;
		end
	end

	// Holding location for fetched data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_o <= WORD_RESET;
		end else if (cop_req_o && cop_ack_i && !cop_we_o) begin
			hold_o <= cop_rdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_read_fetch: assert property (rd_go_i && !busy_o |=>
		cop_req_o && !cop_we_o && cop_addr_o == $past(word_i))
		else $error("read fetch not issued");
	chk_write_target: assert property (dw_go_i && !busy_o && !rd_go_i |=>
		cop_req_o && cop_we_o && cop_addr_o == $past(wr_addr_q))
		else $error("write not aimed at latched address");
	chk_busy_hold: assert property (busy_o && !cop_ack_i |=> busy_o)
		else $error("busy dropped before acknowledge");
	chk_fetch_data: assert property (cop_req_o && cop_ack_i && !cop_we_o |=>
		hold_o == $past(cop_rdata_i))
		else $error("fetched word not held");
	cov_read_done: cover property (rd_go_i && !busy_o ##[1:50] cop_ack_i);
endmodule : vdc_indirect

/* File: src/vdc_ctrl_port.sv */
// Two-wire control port of the video decoder, top level
`timescale 1ns/10ps
module vdc_ctrl_port
	import vdc_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h5a // Arbitrary value
)(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Two-wire bus
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_b_o,
	// Direct control register
	output logic [7:0]       output_enable_control_o,
	// coprocessor_ram port
	output logic             cop_req_o,
	output logic             cop_we_o,
	output logic [15:0]      cop_addr_o,
	output logic [15:0]      cop_wdata_o,
	input  wire logic        cop_ack_i,
	input  wire logic [15:0] cop_rdata_i
);
	vdc_state_type state_q;
	logic          scl_q;
	logic          sda_q;
	logic [3:0]    bitcnt_q;
	logic [7:0]    sr_q;
	logic [7:0]    tx_q;
	logic [7:0]    sub_q;
	logic          sub_seen_q;
	logic          pair_q;
	logic [7:0]    hi_q;
	logic          nack_q;
	logic          busy;
	logic [15:0]   hold;
	logic          start_ev;
	logic          stop_ev;
	logic          rise;
	logic          fall;
	logic          byte_wr;
	logic          data_wr;
	logic          ld_ev;
	logic          word_sub;
	logic          rd_go;
	logic          wa_go;
	logic          dw_go;
	logic [15:0]   word;

	function automatic logic [7:0] read_byte(input logic [7:0]  sub,
	                                          input logic        pair,
	                                          input logic        bsy,
	                                          input logic [15:0] hld,
	                                          input logic [7:0]  oec);
		logic [7:0] r;
		r = 8'h00;
		unique case (sub)
			SUB_MAKER_ID: r = MAKER_ID;
			SUB_STATUS:   r[STATUS_BUSY_BIT] = bsy;
			SUB_DATA:     r = pair ? hld[7:0] : hld[15:8];
			SUB_OUT_EN:   r = oec;
			default:      r = 8'h00;
		endcase
		return r;
	endfunction : read_byte

	////////////////////////////////////////////////////////////////////////////
	// Bus condition detection
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	assign start_ev = scl_q && scl_i && sda_q && !sda_i;
	assign stop_ev  = scl_q && scl_i && !sda_q && sda_i;
	assign rise     = !scl_q && scl_i;
	assign fall     = scl_q && !scl_i;
	assign byte_wr  = fall && (state_q == ST_WRITE) && (bitcnt_q == BITS_IN_BYTE);
	assign data_wr  = byte_wr && sub_seen_q;
	assign ld_ev    = fall && (((state_q == ST_ADACK) && sr_q[0]) ||
	                           ((state_q == ST_RDACK) && !nack_q));
	assign word_sub = (sub_q == SUB_RD_ADDR) || (sub_q == SUB_WR_ADDR) ||
	                  (sub_q == SUB_DATA);

	////////////////////////////////////////////////////////////////////////////
	// Protocol sequencer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
		end else if (start_ev) begin
			state_q <= ST_ADDR;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
		end else if (fall) begin
			unique case (state_q)
				ST_IDLE:  state_q <= ST_IDLE;
				ST_ADDR: begin
					if (bitcnt_q == BITS_IN_BYTE) begin
						state_q <= ({sr_q[7:1], 1'b0} == DEV_WADDR) ? ST_ADACK : ST_IDLE;
					end
				end
				ST_ADACK: state_q <= sr_q[0] ? ST_READ : ST_WRITE;
				ST_WRITE: begin
					if (bitcnt_q == BITS_IN_BYTE) begin
						state_q <= ST_WRACK;
					end
				end
				ST_WRACK: state_q <= ST_WRITE;
				ST_READ: begin
					if (bitcnt_q == LAST_TX_BIT) begin
						state_q <= ST_RDACK;
					end
				end
				ST_RDACK: state_q <= nack_q ? ST_IDLE : ST_READ;
			endcase
		end
	end

	// Bit counter
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bitcnt_q <= 4'h0;
		end else if (start_ev) begin
			bitcnt_q <= 4'h0;
		end else if (rise && (state_q == ST_ADDR || state_q == ST_WRITE)) begin
			bitcnt_q <= bitcnt_q + 4'h1;
		end else if (fall) begin
			if (state_q == ST_READ && bitcnt_q != LAST_TX_BIT) begin
				bitcnt_q <= bitcnt_q + 4'h1;
			end else if (state_q != ST_ADDR && state_q != ST_WRITE) begin
				bitcnt_q <= 4'h0;
			end else if (bitcnt_q == BITS_IN_BYTE) begin
				bitcnt_q <= 4'h0;
			end
		end
	end

	// Receive shift and host acknowledge capture
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sr_q   <= 8'h00;
			nack_q <= 1'b1;
		end else if (rise) begin
			if (state_q == ST_ADDR || state_q == ST_WRITE) begin
				sr_q <= {sr_q[6:0], sda_i};
			end
			if (state_q == ST_RDACK) begin
				nack_q <= sda_i;
			end
		end
	end

	// Transmit shift, high bit first
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_q <= 8'h00;
		end else if (ld_ev) begin
			tx_q <= read_byte(sub_q, pair_q, busy, hold, output_enable_control_o);
		end else if (fall && state_q == ST_READ) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// Open-drain data line: acknowledges and zero bits pull low
	assign sda_o      = 1'b0;
	assign sda_oe_b_o = !((state_q == ST_ADACK) || (state_q == ST_WRACK) ||
	                      (state_q == ST_READ && !tx_q[7]));

	////////////////////////////////////////////////////////////////////////////
	// Subaddress and byte pairing
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sub_q      <= 8'h00;
			sub_seen_q <= 1'b0;
		end else if (start_ev) begin
			sub_seen_q <= 1'b0;
		end else if (byte_wr && !sub_seen_q) begin
			sub_q      <= sr_q;
			sub_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pair_q <= 1'b0;
			hi_q   <= 8'h00;
		end else if (byte_wr && !sub_seen_q) begin
			pair_q <= 1'b0;
		end else if (data_wr && word_sub) begin
			pair_q <= !pair_q;
			if (!pair_q) begin
				hi_q <= sr_q;
			end
		end else if (ld_ev && sub_q == SUB_DATA) begin
			pair_q <= !pair_q;
		end
	end

	assign word  = {hi_q, sr_q};
	assign rd_go = data_wr && pair_q && (sub_q == SUB_RD_ADDR);
	assign wa_go = data_wr && pair_q && (sub_q == SUB_WR_ADDR);
	assign dw_go = data_wr && pair_q && (sub_q == SUB_DATA);

	// Direct writable register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			output_enable_control_o <= OUT_EN_RESET;
		end else if (data_wr && sub_q == SUB_OUT_EN) begin
			output_enable_control_o <= sr_q;
		end
	end

	vdc_indirect u_indirect (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.rd_go_i     (rd_go),
		.wa_go_i     (wa_go),
		.dw_go_i     (dw_go),
		.word_i      (word),
		.busy_o      (busy),
		.hold_o      (hold),
		.cop_req_o   (cop_req_o),
		.cop_we_o    (cop_we_o),
		.cop_addr_o  (cop_addr_o),
		.cop_wdata_o (cop_wdata_o),
		.cop_ack_i   (cop_ack_i),
		.cop_rdata_i (cop_rdata_i)
	);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_addr_ack: assert property (fall && state_q == ST_ADDR && bitcnt_q == BITS_IN_BYTE &&
		{sr_q[7:1], 1'b0} == DEV_WADDR && !start_ev && !stop_ev |=> !sda_oe_b_o)
		else $error("own address not acknowledged");
	chk_sub_latch: assert property (byte_wr && !sub_seen_q && !start_ev |=>
		sub_q == $past(sr_q) && sub_seen_q)
		else $error("subaddress not latched");
	chk_oec_store: assert property (data_wr && sub_q == SUB_OUT_EN |=>
		output_enable_control_o == $past(sr_q))
		else $error("control byte not stored");
	chk_id_read: assert property (ld_ev && sub_q == SUB_MAKER_ID |=> tx_q == MAKER_ID)
		else $error("identification byte wrong");
	chk_busy_bit: assert property (ld_ev && sub_q == SUB_STATUS |=>
		tx_q[STATUS_BUSY_BIT] == $past(busy))
		else $error("busy bit not reported");
	chk_msb_first: assert property (ld_ev && sub_q == SUB_DATA && !pair_q |=>
		tx_q == $past(hold[15:8]) ##0 pair_q)
		else $error("high byte not sent first");
	chk_pair_done: assert property (data_wr && word_sub && !pair_q && !busy |=>
		!busy && pair_q && hi_q == $past(sr_q))
		else $error("word issued on first byte");
	chk_wa_issue: assert property (data_wr && pair_q && sub_q == SUB_WR_ADDR && !busy |=>
		u_indirect.wr_addr_q == {$past(hi_q), $past(sr_q)})
		else $error("write address not latched");

	cov_direct_write: cover property (data_wr && sub_q == SUB_OUT_EN);
	cov_id_read: cover property (ld_ev && sub_q == SUB_MAKER_ID);
	cov_data_word: cover property (dw_go ##[1:20] cop_ack_i);
endmodule : vdc_ctrl_port

/* File: test/vdc_host_model.sv */
// Behavioural two-wire bus host driving the control port
`timescale 1ns/10ps
module vdc_host_model (
	// Clock
	input  wire logic clk_i,
	// Two-wire bus
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	// Data moves only in the low phase
	task bit_out(input logic v);
		sda_o = v;
		tick(4);
		scl_o = 1'b1;
		tick(6);
		scl_o = 1'b0;
		tick(2);
	endtask : bit_out

	task bit_in(output logic v);
		sda_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(3);
		v = sda_i;
		tick(3);
		scl_o = 1'b0;
		tick(2);
	endtask : bit_in

	////////////////////////////////////////////////////////////////
	// Also serves as repeated start
	task start();
		sda_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(6);
		sda_o = 1'b0;
		tick(6);
		scl_o = 1'b0;
		tick(2);
	endtask : start

	task stop();
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(6);
		sda_o = 1'b1;
		tick(6);
	endtask : stop

	task put(input logic [7:0] b, output logic nak);
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(nak);
	endtask : put

	task get(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_in(b[i]);
		bit_out(last);
	endtask : get
endmodule : vdc_host_model

/* File: test/vdc_ctrl_port_test.sv */
// Self-checking bench for the two-wire control port
`timescale 1ns/10ps
module vdc_ctrl_port_test
	import vdc_pkg::*;
;
	localparam logic [7:0] ID_VALUE = 8'hc3; // Arbitrary value

	logic        clk = 1'b0;
	logic        rst_b;
	logic        scl;
	logic        host_sda;
	logic        sda;
	logic        sda_o;
	logic        sda_oe_b;
	logic        cop_req;
	logic        cop_we;
	logic        cop_ack;
	logic        slow;
	logic [7:0]  oec;
	logic [15:0] cop_addr;
	logic [15:0] cop_wdata;
	logic [15:0] cop_rdata;
	logic [15:0] mem [0:65535];
	logic [31:0] seed = 32'h51;
	int          miscompares = 0;
	int          check_count = 0;

	always #5 clk = ~clk;
	// Open-drain wire with pull-up
	assign sda = host_sda & (sda_oe_b | sda_o);

	vdc_ctrl_port #(
		.MAKER_ID(ID_VALUE)
	) i_dut (
		.clk_i                  (clk),
		.rst_b_i                (rst_b),
		.scl_i                  (scl),
		.sda_i                  (sda),
		.sda_o                  (sda_o),
		.sda_oe_b_o             (sda_oe_b),
		.output_enable_control_o(oec),
		.cop_req_o              (cop_req),
		.cop_we_o               (cop_we),
		.cop_addr_o             (cop_addr),
		.cop_wdata_o            (cop_wdata),
		.cop_ack_i              (cop_ack),
		.cop_rdata_i            (cop_rdata)
	);

	vdc_host_model i_host (
		.clk_i(clk),
		.sda_i(sda),
		.scl_o(scl),
		.sda_o(host_sda)
	);

	////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function logic [15:0] exp_status(input logic busy);
		return 16'(busy) << STATUS_BUSY_BIT;
	endfunction : exp_status

	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	task wrap_up();
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////
	// Coprocessor RAM, prompt or slow
	initial begin
		cop_ack = 1'b0;
		cop_rdata = 16'h0000;
		forever begin
			@(posedge clk);
			#1;
			if (cop_req === 1'b1) begin
				repeat (slow ? 1500 : rnd() % 4) begin
					@(posedge clk);
					#1;
				end
				cop_ack = 1'b1;
				if (cop_we)
					mem[cop_addr] = cop_wdata;
				else
					cop_rdata = mem[cop_addr];
				@(posedge clk);
				#1;
				cop_ack = 1'b0;
				cop_rdata = ~cop_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	task reg_wr(input logic [7:0] sub, input logic [15:0] d, input int n);
		logic nak;
		logic any;
		i_host.start();
		i_host.put(DEV_WADDR, any);
		i_host.put(sub, nak);
		any |= nak;
		for (int i = n - 1; i >= 0; i--) begin
			i_host.put(d[8*i +: 8], nak);
			any |= nak;
		end
		i_host.stop();
		check("write ack", 16'h0000, 16'(any));
	endtask : reg_wr

	task reg_rd(input logic [7:0] sub, input int n, output logic [15:0] v);
		logic       nak;
		logic       any;
		logic [7:0] b;
		v = 16'h0000;
		i_host.start();
		i_host.put(DEV_WADDR, any);
		i_host.put(sub, nak);
		any |= nak;
		i_host.start();
		i_host.put(DEV_RADDR, nak);
		any |= nak;
		for (int i = 0; i < n; i++) begin
			i_host.get(i == n - 1, b);
			v = {v[7:0], b};
		end
		i_host.stop();
		check("read ack", 16'h0000, 16'(any));
	endtask : reg_rd

	task wait_idle();
		logic [15:0] v;
		int          tries;
		tries = 0;
		do begin
			reg_rd(SUB_STATUS, 1, v);
			tries++;
		end while (v[STATUS_BUSY_BIT] !== 1'b0 && tries < 20);
		check("busy clear", exp_status(1'b0), v);
	endtask : wait_idle

	////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] v;
		logic [15:0] a;
		logic [15:0] w;
		logic        nak;
		rst_b = 1'b0;
		slow = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("out enable reset", {8'h00, OUT_EN_RESET}, {8'h00, oec});
		reg_rd(SUB_MAKER_ID, 1, v);
		check("maker id", {8'h00, ID_VALUE}, v);
		i_host.start();
		i_host.put(8'h88, nak);
		i_host.stop();
		check("foreign nak", 16'h0001, 16'(nak));
		reg_rd(8'h40, 1, v);
		check("unmapped read", 16'h0000, v);
		for (int k = 0; k < 4; k++) begin
			w = 16'(rnd());
			reg_wr(SUB_OUT_EN, w, 1);
			check("out enable", {8'h00, w[7:0]}, {8'h00, oec});
			reg_rd(SUB_OUT_EN, 1, v);
			check("out enable read", {8'h00, w[7:0]}, v);
			a = 16'(rnd());
			w = 16'(rnd());
			wait_idle();
			reg_wr(SUB_WR_ADDR, a, 2);
			wait_idle();
			reg_wr(SUB_DATA, w, 2);
			wait_idle();
			check("written word", w, mem[a]);
			a = a ^ 16'h8001;
			mem[a] = 16'(rnd());
			reg_wr(SUB_RD_ADDR, a, 2);
			wait_idle();
			reg_rd(SUB_DATA, 2, v);
			check("fetched word", mem[a], v);
		end
		// Slow RAM keeps the transfer pending
		slow = 1'b1;
		a = 16'(rnd());
		w = 16'(rnd());
		wait_idle();
		reg_wr(SUB_WR_ADDR, a, 2);
		wait_idle();
		reg_wr(SUB_DATA, w, 2);
		reg_rd(SUB_STATUS, 1, v);
		check("busy set", exp_status(1'b1), v);
		check("req kind", 16'h0001, 16'(cop_we));
		check("req address", a, cop_addr);
		check("req data", w, cop_wdata);
		wait_idle();
		slow = 1'b0;
		check("slow word", w, mem[a]);
		wrap_up();
	end

	initial begin
		#600000;
		miscompares++;
		wrap_up();
	end
endmodule : vdc_ctrl_port_test
